// ---- rtl/pio_pkg.sv ----
// package: register map, reset values and carrier types of the parallel ports
package pio_pkg;

  // register bank select values
  localparam logic [3:0] PIO_BANK_0                 = 4'h0;
  localparam logic [3:0] PIO_BANK_1                 = 4'h1;

  // register offsets inside a bank
  localparam logic [7:0] PIO_OFS_ZERO_PORT          = 8'h10; // bank 0
  localparam logic [7:0] PIO_OFS_FIRST_PORT_DIR     = 8'h11; // bank 0
  localparam logic [7:0] PIO_OFS_FIRST_PORT_DATA    = 8'h12; // bank 0
  localparam logic [7:0] PIO_OFS_LOW_BUS_PORT_DIR   = 8'h10; // bank 1
  localparam logic [7:0] PIO_OFS_LOW_BUS_PORT_DATA  = 8'h11; // bank 1
  localparam logic [7:0] PIO_OFS_HIGH_BUS_PORT_DIR  = 8'h12; // bank 1
  localparam logic [7:0] PIO_OFS_HIGH_BUS_PORT_DATA = 8'h13; // bank 1
  localparam logic [7:0] PIO_OFS_PERIPH_FLAGS_ONE   = 8'h16; // bank 1
  localparam logic [7:0] PIO_OFS_PERIPH_ENABLES_ONE = 8'h17; // bank 1

  // field positions
  localparam int         PIO_BIT_PULLUP_DISABLE_N   = 7;
  localparam int         PIO_BIT_PORT_CHANGE        = 7;
  localparam int         PIO_BIT_CAPTURE_ONE        = 0;
  localparam int         PIO_BIT_CAPTURE_TWO        = 1;
  localparam int         PIO_BIT_MODULATOR_ONE      = 2;
  localparam int         PIO_BIT_MODULATOR_TWO      = 3;
  localparam int         PIO_BIT_TIMER_ONE_TWO_CLK  = 4;
  localparam int         PIO_BIT_TIMER_THREE_CLK    = 5;
  localparam int         PIO_BIT_SPI_CLOCK          = 6;
  localparam int         PIO_BIT_SPI_DATA_OUT       = 7;

  // values after reset
  localparam logic [7:0] PIO_RST_DIRECTION          = 8'hff;
  localparam logic [7:0] PIO_RST_ENABLES_ONE        = 8'h00;
  localparam logic       PIO_RST_PULLUP_DISABLE_N   = 1'b0;
  localparam logic       PIO_RST_PORT_CHANGE        = 1'b0;
  localparam logic [7:0] PIO_RST_READ_DATA          = 8'h00;

  // processor memory modes from the configuration bits
  typedef enum logic [1:0] {
    PIO_MODE_MICROPROCESSOR,
    PIO_MODE_EXT_MICROCONTROLLER,
    PIO_MODE_MICROCONTROLLER,
    PIO_MODE_PROTECTED_MICROCONTROLLER
  } pio_mode_t;

  // one register access from the processor core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pio_reg_req_t;

  // drive side of one 8-bit port
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
  } pio_pin_drive_t;

endpackage : pio_pkg

// ---- rtl/pio_ports.sv ----
// module: first port, low-byte and high-byte bus ports with change detect
//
// Operation
// - low bus port: eight pins, one means input
// - low bus port reads pins, writes latch
// - low bus port carries bus low byte
// - bus modes turn both ports into bus
// - high bus port: eight pins, one means input
// - high bus port reads pins, writes latch
// - high bus port carries bus high byte
// - bus port pins: gpio or address/data line
// - first port bits 0,1 feed captures
// - first port bits 2,3 carry modulators
// - first port bits 4,5 feed timer clocks
// - first port bits 6,7 carry spi
// - all first port pins: pull-up, change detect
// - low bus direction resets to all ones
// - first port direction: one means input
// - pull-ups: global enable, off on outputs
// - input-pin mismatches set change flag
`timescale 1ns/10ps

module pio_ports
  import pio_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire pio_mode_t      mem_mode,
  input  wire pio_reg_req_t   reg_req,
  output logic [7:0]          reg_rdata,
  input  wire logic [7:0]     pb_pin_in,
  output pio_pin_drive_t      pb_drive,
  output logic [7:0]          pb_pullup_en,
  input  wire logic [7:0]     pc_pin_in,
  output pio_pin_drive_t      pc_drive,
  input  wire logic [7:0]     pd_pin_in,
  output pio_pin_drive_t      pd_drive,
  input  wire logic [15:0]    bus_ad_out,
  input  wire logic           bus_ad_oe_n,
  output logic [15:0]         bus_ad_in,
  output logic                bus_active,
  input  wire logic           modulator_one_en,
  input  wire logic           modulator_one_output,
  input  wire logic           modulator_two_en,
  input  wire logic           modulator_two_output,
  input  wire logic           spi_en,
  input  wire logic           spi_clock_out,
  input  wire logic           spi_clock_oe_n,
  input  wire logic           spi_data_out,
  output logic                capture_one_input,
  output logic                capture_two_input,
  output logic                timer_one_two_ext_clock,
  output logic                timer_three_ext_clock,
  output logic                spi_clock_in,
  output logic                port_change_flag,
  output logic                port_change_irq
);

  logic [WIDTH-1:0] b_meta_reg, b_sync_reg, c_meta_reg, c_sync_reg, d_meta_reg, d_sync_reg;
  logic [WIDTH-1:0] b_lat_reg, c_lat_reg, d_lat_reg;
  logic [WIDTH-1:0] b_dir_reg, c_dir_reg, d_dir_reg;
  logic [WIDTH-1:0] enables_one_reg;
  logic             pullup_disable_n_reg;
  logic             change_flag_reg;
  logic [WIDTH-1:0] b_dout_next, b_oe_n_next;
  logic [WIDTH-1:0] mismatch;
  logic             bus_mode_next;

  function automatic logic hit(input pio_reg_req_t req, input logic [3:0] bank, input logic [7:0] ofs);
    hit = (req.bank == bank) && (req.addr == ofs);
  endfunction

  // pins cross into the clock domain through two flip-flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      b_meta_reg <= '0;
      b_sync_reg <= '0;
      c_meta_reg <= '0;
      c_sync_reg <= '0;
      d_meta_reg <= '0;
      d_sync_reg <= '0;
    end else begin
      b_meta_reg <= pb_pin_in;
      b_sync_reg <= b_meta_reg;
      c_meta_reg <= pc_pin_in;
      c_sync_reg <= c_meta_reg;
      d_meta_reg <= pd_pin_in;
      d_sync_reg <= d_meta_reg;
    end
  end

  // latches keep value
  // no reset on purpose: an external reset must leave the latches alone
  always_ff @(posedge clk_sys) begin
    if (reg_req.wr && hit(reg_req, PIO_BANK_1, PIO_OFS_LOW_BUS_PORT_DATA)) begin
      c_lat_reg <= reg_req.wdata;
    end
    if (reg_req.wr && hit(reg_req, PIO_BANK_1, PIO_OFS_HIGH_BUS_PORT_DATA)) begin
      d_lat_reg <= reg_req.wdata;
    end
    if (reg_req.wr && hit(reg_req, PIO_BANK_0, PIO_OFS_FIRST_PORT_DATA)) begin
      b_lat_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      b_dir_reg <= PIO_RST_DIRECTION;
      c_dir_reg <= PIO_RST_DIRECTION;
      d_dir_reg <= PIO_RST_DIRECTION;
    end else begin
      if (reg_req.wr && hit(reg_req, PIO_BANK_0, PIO_OFS_FIRST_PORT_DIR)) begin
        b_dir_reg <= reg_req.wdata;
      end
      if (reg_req.wr && hit(reg_req, PIO_BANK_1, PIO_OFS_LOW_BUS_PORT_DIR)) begin
        c_dir_reg <= reg_req.wdata;
      end
      if (reg_req.wr && hit(reg_req, PIO_BANK_1, PIO_OFS_HIGH_BUS_PORT_DIR)) begin
        d_dir_reg <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pullup_disable_n_reg <= PIO_RST_PULLUP_DISABLE_N;
      enables_one_reg      <= PIO_RST_ENABLES_ONE;
    end else begin
      if (reg_req.wr && hit(reg_req, PIO_BANK_0, PIO_OFS_ZERO_PORT)) begin
        pullup_disable_n_reg <= reg_req.wdata[PIO_BIT_PULLUP_DISABLE_N];
      end
      if (reg_req.wr && hit(reg_req, PIO_BANK_1, PIO_OFS_PERIPH_ENABLES_ONE)) begin
        enables_one_reg <= reg_req.wdata;
      end
    end
  end

  assign mismatch = (b_sync_reg ^ b_lat_reg) & b_dir_reg;

  // flag at bit 7
  // set wins over a clear in the same cycle, so a held mismatch re-flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      change_flag_reg <= PIO_RST_PORT_CHANGE;
    end else if (|mismatch) begin
      change_flag_reg <= 1'b1;
    end else if (reg_req.wr && hit(reg_req, PIO_BANK_1, PIO_OFS_PERIPH_FLAGS_ONE)) begin
      change_flag_reg <= reg_req.wdata[PIO_BIT_PORT_CHANGE];
    end
  end

  assign bus_mode_next = (mem_mode == PIO_MODE_MICROPROCESSOR) || (mem_mode == PIO_MODE_EXT_MICROCONTROLLER);

  always_comb begin
    b_dout_next = b_lat_reg;
    b_oe_n_next = b_dir_reg;
    if (modulator_one_en) begin
      b_dout_next[PIO_BIT_MODULATOR_ONE] = modulator_one_output;
      b_oe_n_next[PIO_BIT_MODULATOR_ONE] = 1'b0;
    end
    if (modulator_two_en) begin
      b_dout_next[PIO_BIT_MODULATOR_TWO] = modulator_two_output;
      b_oe_n_next[PIO_BIT_MODULATOR_TWO] = 1'b0;
    end
    if (spi_en) begin
      b_dout_next[PIO_BIT_SPI_CLOCK]    = spi_clock_out;
      b_oe_n_next[PIO_BIT_SPI_CLOCK]    = spi_clock_oe_n;
      b_dout_next[PIO_BIT_SPI_DATA_OUT] = spi_data_out;
      b_oe_n_next[PIO_BIT_SPI_DATA_OUT] = 1'b0;
    end
  end

  // first port pin drive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pb_drive     <= '{dout: 8'h00, oe_n: PIO_RST_DIRECTION};
      pb_pullup_en <= {WIDTH{~PIO_RST_PULLUP_DISABLE_N}};
    end else begin
      pb_drive     <= '{dout: b_dout_next, oe_n: b_oe_n_next};
      pb_pullup_en <= b_oe_n_next & {WIDTH{~pullup_disable_n_reg}};
    end
  end

  // bus owns the pins in bus modes, latches and directions otherwise
  // bus pins share one enable: the controller turns the whole bus at once
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc_drive   <= '{dout: 8'h00, oe_n: PIO_RST_DIRECTION};
      pd_drive   <= '{dout: 8'h00, oe_n: PIO_RST_DIRECTION};
      bus_active <= 1'b0;
    end else if (bus_mode_next) begin
      pc_drive   <= '{dout: bus_ad_out[7:0], oe_n: {WIDTH{bus_ad_oe_n}}};
      pd_drive   <= '{dout: bus_ad_out[15:8], oe_n: {WIDTH{bus_ad_oe_n}}};
      bus_active <= 1'b1;
    end else begin
      pc_drive   <= '{dout: c_lat_reg, oe_n: c_dir_reg};
      pd_drive   <= '{dout: d_lat_reg, oe_n: d_dir_reg};
      bus_active <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_ad_in               <= '0;
      capture_one_input       <= 1'b0;
      capture_two_input       <= 1'b0;
      timer_one_two_ext_clock <= 1'b0;
      timer_three_ext_clock   <= 1'b0;
      spi_clock_in            <= 1'b0;
    end else begin
      bus_ad_in               <= {d_sync_reg, c_sync_reg};
      capture_one_input       <= b_sync_reg[PIO_BIT_CAPTURE_ONE];
      capture_two_input       <= b_sync_reg[PIO_BIT_CAPTURE_TWO];
      timer_one_two_ext_clock <= b_sync_reg[PIO_BIT_TIMER_ONE_TWO_CLK];
      timer_three_ext_clock   <= b_sync_reg[PIO_BIT_TIMER_THREE_CLK];
      spi_clock_in            <= b_sync_reg[PIO_BIT_SPI_CLOCK];
    end
  end

  // interrupt request and wake level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port_change_flag <= 1'b0;
      port_change_irq  <= 1'b0;
    end else begin
      port_change_flag <= change_flag_reg;
      port_change_irq  <= change_flag_reg & enables_one_reg[PIO_BIT_PORT_CHANGE];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= PIO_RST_READ_DATA;
    end else if (reg_req.rd) begin
      if (hit(reg_req, PIO_BANK_0, PIO_OFS_ZERO_PORT)) begin
        reg_rdata <= {pullup_disable_n_reg, 7'h00};
      end else if (hit(reg_req, PIO_BANK_0, PIO_OFS_FIRST_PORT_DIR)) begin
        reg_rdata <= b_dir_reg;
      end else if (hit(reg_req, PIO_BANK_0, PIO_OFS_FIRST_PORT_DATA)) begin
        reg_rdata <= b_sync_reg;
      end else if (hit(reg_req, PIO_BANK_1, PIO_OFS_LOW_BUS_PORT_DIR)) begin
        reg_rdata <= c_dir_reg;
      end else if (hit(reg_req, PIO_BANK_1, PIO_OFS_LOW_BUS_PORT_DATA)) begin
        reg_rdata <= c_sync_reg;
      end else if (hit(reg_req, PIO_BANK_1, PIO_OFS_HIGH_BUS_PORT_DIR)) begin
        reg_rdata <= d_dir_reg;
      end else if (hit(reg_req, PIO_BANK_1, PIO_OFS_HIGH_BUS_PORT_DATA)) begin
        reg_rdata <= d_sync_reg;
      end else if (hit(reg_req, PIO_BANK_1, PIO_OFS_PERIPH_FLAGS_ONE)) begin
        reg_rdata <= {change_flag_reg, 7'h00};
      end else if (hit(reg_req, PIO_BANK_1, PIO_OFS_PERIPH_ENABLES_ONE)) begin
        reg_rdata <= enables_one_reg;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_low_gpio_drive: assert property (
    !bus_mode_next && !c_dir_reg[0] |=> !pc_drive.oe_n[0] && pc_drive.dout[0] == $past(c_lat_reg[0]))
    else $error("low port output pin not driven from latch");
  a_low_write_latch: assert property (
    reg_req.wr && hit(reg_req, PIO_BANK_1, PIO_OFS_LOW_BUS_PORT_DATA) |=> c_lat_reg == $past(reg_req.wdata))
    else $error("low port write did not reach latch");
  a_low_read_pins: assert property (
    reg_req.rd && hit(reg_req, PIO_BANK_1, PIO_OFS_LOW_BUS_PORT_DATA) |=> reg_rdata == $past(c_sync_reg))
    else $error("low port read did not return pins");
  a_bus_low_byte: assert property (
    bus_mode_next |=> bus_active && pc_drive.dout == $past(bus_ad_out[7:0]))
    else $error("low byte not carried in bus mode");
  a_bus_high_byte: assert property (
    bus_mode_next |=> pd_drive.dout == $past(bus_ad_out[15:8]) && pd_drive.oe_n == {WIDTH{$past(bus_ad_oe_n)}})
    else $error("high byte not carried in bus mode");
  a_gpio_mode_off: assert property (
    !bus_mode_next |=> !bus_active ##1 (bus_active == $past(bus_mode_next)))
    else $error("bus ports left in bus mode");
  a_high_write_latch: assert property (
    reg_req.wr && hit(reg_req, PIO_BANK_1, PIO_OFS_HIGH_BUS_PORT_DATA) |=> d_lat_reg == $past(reg_req.wdata))
    else $error("high port write did not reach latch");
  a_pullup_output_off: assert property (
    (pb_pullup_en & ~pb_drive.oe_n) == 8'h00)
    else $error("pull-up on while pin drives");
  a_mismatch_sets_flag: assert property (
    |mismatch |=> change_flag_reg ##1 port_change_flag)
    else $error("mismatch did not set change flag");
  a_modulator_owns_pin: assert property (
    modulator_one_en |=> !pb_drive.oe_n[2] && pb_drive.dout[2] == $past(modulator_one_output))
    else $error("modulator one not on its pin");
  a_irq_gating: assert property (
    change_flag_reg && enables_one_reg[7] |=> port_change_irq)
    else $error("enabled change flag raised no request");

  c_flag_set: cover property (|mismatch ##1 change_flag_reg);
  c_flag_cleared: cover property (change_flag_reg ##1 !change_flag_reg);
  c_bus_drive: cover property (bus_active && !pc_drive.oe_n[0]);
  c_first_read: cover property (reg_req.rd && hit(reg_req, PIO_BANK_0, PIO_OFS_FIRST_PORT_DATA));

endmodule // pio_ports

// ---- verification/pio_pin_model.sv ----
// pin model: resolves one port's pins from device drive, far-side drive and pull-ups
`timescale 1ns/10ps

module pio_pin_model
  import pio_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire pio_pin_drive_t drive,
  input  wire logic [7:0]     pullup_en,
  input  wire logic [7:0]     ext_val,
  input  wire logic [7:0]     ext_en_n,
  output logic [7:0]          pin_level
);
  logic [7:0] float_reg;

  // a floating line must not keep a stale level
  initial float_reg = 8'h5a;
  always @(posedge clk_sys) float_reg <= ~float_reg;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!drive.oe_n[i]) pin_level[i] = drive.dout[i];
      else if (!ext_en_n[i]) pin_level[i] = ext_val[i];
      else if (pullup_en[i]) pin_level[i] = 1'b1;
      else pin_level[i] = float_reg[i];
    end
  end
endmodule // pio_pin_model

// ---- verification/tb.sv ----
// testbench: registers, pins, change detect, alternate functions and bus mode
`timescale 1ns/10ps

module tb
  import pio_pkg::*;
;
  localparam logic [3:0] B0 = PIO_BANK_0;
  localparam logic [3:0] B1 = PIO_BANK_1;
  localparam logic [3:0] BK [3] = '{B0, B1, B1};
  localparam logic [7:0] DAT [3] = '{PIO_OFS_FIRST_PORT_DATA, PIO_OFS_LOW_BUS_PORT_DATA, PIO_OFS_HIGH_BUS_PORT_DATA};
  localparam logic [7:0] DIR [3] = '{PIO_OFS_FIRST_PORT_DIR, PIO_OFS_LOW_BUS_PORT_DIR, PIO_OFS_HIGH_BUS_PORT_DIR};
  logic           clk_sys;
  logic           rst_n;
  pio_mode_t      mem_mode;
  pio_reg_req_t   reg_req;
  logic [7:0]     reg_rdata;
  pio_pin_drive_t drv [3];
  logic [7:0]     pins [3];
  logic [7:0]     pull [3];
  logic [7:0]     ext_val [3];
  logic [7:0]     ext_en_n [3];
  logic [7:0]     lat [3];
  logic [15:0]    bus_ad_out;
  logic           bus_ad_oe_n;
  logic [15:0]    bus_ad_in;
  logic           bus_active;
  logic [3:0]     alt_en;
  logic [3:0]     alt_val;
  logic [4:0]     alt_in;
  logic           port_change_flag;
  logic           port_change_irq;
  logic           rd_seen;
  logic [7:0]     exp_q [$];
  logic [31:0]    seed;
  logic [7:0]     v;
  int             error_cnt;
  int             cmp_count;

  pio_ports i_pio_ports (
    .clk_sys(clk_sys), .rst_n(rst_n), .mem_mode(mem_mode), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pb_pin_in(pins[0]), .pb_drive(drv[0]), .pb_pullup_en(pull[0]),
    .pc_pin_in(pins[1]), .pc_drive(drv[1]), .pd_pin_in(pins[2]), .pd_drive(drv[2]),
    .bus_ad_out(bus_ad_out), .bus_ad_oe_n(bus_ad_oe_n), .bus_ad_in(bus_ad_in), .bus_active(bus_active),
    .modulator_one_en(alt_en[0]), .modulator_one_output(alt_val[0]),
    .modulator_two_en(alt_en[1]), .modulator_two_output(alt_val[1]),
    .spi_en(alt_en[2]), .spi_clock_oe_n(alt_en[3]), .spi_clock_out(alt_val[2]), .spi_data_out(alt_val[3]),
    .capture_one_input(alt_in[0]), .capture_two_input(alt_in[1]), .timer_one_two_ext_clock(alt_in[2]),
    .timer_three_ext_clock(alt_in[3]), .spi_clock_in(alt_in[4]),
    .port_change_flag(port_change_flag), .port_change_irq(port_change_irq)
  );

  // bus ports have no pull-ups
  assign pull[1] = 8'h00;
  assign pull[2] = 8'h00;

  for (genvar g = 0; g < 3; g++) begin : g_pin
    pio_pin_model i_pio_pin_model (
      .clk_sys(clk_sys), .drive(drv[g]), .pullup_en(pull[g]),
      .ext_val(ext_val[g]), .ext_en_n(ext_en_n[g]), .pin_level(pins[g])
    );
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // two cycles per access, so the request never changes twice in one step
  task automatic acc(input logic w, input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
    if (!w) exp_q.push_back(d);
    reg_req = '{wr: w, rd: !w, bank: b, addr: a, wdata: w ? d : 8'h00};
    @(negedge clk_sys);
    reg_req = '0;
    @(negedge clk_sys);
  endtask

  task automatic settle();
    repeat (4) @(negedge clk_sys);
  endtask

  // read answers at the taking edge and is checked at the next falling edge
  always @(posedge clk_sys) rd_seen <= reg_req.rd;
  always @(negedge clk_sys) begin
    if (rd_seen && exp_q.size() > 0) check(16'(reg_rdata), 16'(exp_q.pop_front()));
  end

  initial begin
    #300000;
    error_cnt++;
    final_report();
  end

  initial begin
    seed = 32'hb10b;
    rst_n = 1'b0;
    mem_mode = PIO_MODE_MICROCONTROLLER;
    reg_req = '0;
    bus_ad_out = 16'h0000;
    bus_ad_oe_n = 1'b1;
    alt_en = 4'h8;
    alt_val = 4'h0;
    ext_val = '{8'h00, 8'h00, 8'h00};
    ext_en_n = '{8'hff, 8'hff, 8'hff};
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    check(16'(pull[0]), 16'h00ff);
    acc(0, B0, DIR[0], 8'hff);
    acc(0, B1, DIR[1], 8'hff);
    acc(0, B1, DIR[2], 8'hff);
    acc(0, B1, PIO_OFS_PERIPH_ENABLES_ONE, 8'h00);
    acc(0, B0, PIO_OFS_ZERO_PORT, 8'h00);
    acc(0, B1, 8'h14, 8'h00);
    // latch drives outputs, reads see pins
    for (int p = 0; p < 3; p++) begin
      lat[p] = 8'(xs());
      acc(1, BK[p], DAT[p], lat[p]);
      acc(1, BK[p], DIR[p], 8'h00);
      check(16'(drv[p].oe_n), 16'h0000);
      check(16'(drv[p].dout), 16'(lat[p]));
      settle();
      acc(0, BK[p], DAT[p], lat[p]);
      acc(1, BK[p], DIR[p], 8'hff);
      ext_val[p] = ~lat[p];
      ext_en_n[p] = 8'h00;
      settle();
      check(16'(drv[p].oe_n), 16'h00ff);
      acc(0, BK[p], DAT[p], ~lat[p]);
      ext_en_n[p] = 8'hff;
    end
    // pull-ups off on outputs and by global disable
    acc(1, B0, DIR[0], 8'h0f);
    check(16'(pull[0]), 16'h000f);
    acc(1, B0, PIO_OFS_ZERO_PORT, 8'hff);
    check(16'(pull[0]), 16'h0000);
    acc(0, B0, PIO_OFS_ZERO_PORT, 8'h80);
    acc(1, B0, PIO_OFS_ZERO_PORT, 8'h00);
    acc(1, B0, DIR[0], 8'hff);
    // every pin raises the change flag, interrupt request masked on odd pins
    ext_val[0] = lat[0];
    ext_en_n[0] = 8'h00;
    settle();
    acc(1, B1, PIO_OFS_PERIPH_FLAGS_ONE, 8'h00);
    settle();
    check(16'(port_change_flag), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      acc(1, B1, PIO_OFS_PERIPH_ENABLES_ONE, i[0] ? 8'h00 : 8'h80);
      v = lat[0] ^ (8'h01 << i);
      ext_val[0] = v;
      for (int t = 0; t < 8 && port_change_flag !== 1'b1; t++) @(negedge clk_sys);
      check(16'(port_change_flag), 16'h0001);
      check(16'(port_change_irq), 16'(!i[0]));
      acc(1, B1, PIO_OFS_PERIPH_FLAGS_ONE, 8'h00);
      settle();
      check(16'(port_change_flag), 16'h0001);
      acc(0, B0, DAT[0], v);
      acc(1, B0, DAT[0], v);
      lat[0] = v;
      acc(1, B1, PIO_OFS_PERIPH_FLAGS_ONE, 8'h00);
      settle();
      check(16'(port_change_flag), 16'h0000);
    end
    acc(0, B1, PIO_OFS_PERIPH_FLAGS_ONE, 8'h00);
    ext_en_n[0] = 8'hcc;
    for (int k = 0; k < 4; k++) begin
      ext_val[0] = 8'(xs());
      alt_val = 4'(xs());
      alt_en = 4'h7;
      settle();
      check(16'(drv[0].oe_n), 16'h0033);
      check(16'({drv[0].dout[7:6], drv[0].dout[3:2]}), 16'(alt_val));
      check(16'({alt_in[3:2], alt_in[1:0]}), 16'({ext_val[0][5:4], ext_val[0][1:0]}));
      check(16'(alt_in[4]), 16'(alt_val[2]));
    end
    alt_en = 4'h8;
    ext_en_n[0] = 8'hff;
    // mid-run reset keeps latches, restores directions and pull-ups
    rst_n = 1'b0;
    @(negedge clk_sys);
    check(16'(pull[0]), 16'h00ff);
    @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    acc(0, B1, DIR[1], 8'hff);
    acc(1, B0, DIR[0], 8'h00);
    check(16'(drv[0].dout), 16'(lat[0]));
    acc(1, B0, DIR[0], 8'hff);
    // bus modes take over both bus ports
    acc(1, B1, DIR[1], 8'h00);
    acc(1, B1, DIR[2], 8'h00);
    for (int m = 0; m < 4; m++) begin
      mem_mode = pio_mode_t'(m);
      bus_ad_out = 16'(xs());
      bus_ad_oe_n = 1'b0;
      settle();
      check(16'(bus_active), 16'(m < 2));
      if (m < 2) begin
        check({drv[2].dout, drv[1].dout}, bus_ad_out);
        check({drv[2].oe_n, drv[1].oe_n}, 16'h0000);
        bus_ad_oe_n = 1'b1;
        ext_val[1] = 8'(xs());
        ext_val[2] = 8'(xs());
        ext_en_n[1] = 8'h00;
        ext_en_n[2] = 8'h00;
        settle();
        check(bus_ad_in, {ext_val[2], ext_val[1]});
        ext_en_n[1] = 8'hff;
        ext_en_n[2] = 8'hff;
      end else begin
        check({drv[2].dout, drv[1].dout}, {lat[2], lat[1]});
      end
    end
    settle();
    check(16'(exp_q.size()), 16'h0000);
    final_report();
  end
endmodule // tb
